/* File: hdl/sample_fifo_defines.vh */
// Register map, field positions, reset values and entry format of the sample FIFO.
// Assumes a byte-wide register port clocked by the same system clock as the FIFO.
// How it works
// - Write index steps by one for every stored entry, addressing the next free slot.
// - Write index wraps from 7F back to 00.
// - Read index steps once per popped entry and wraps from 7F to 00.
// - Host may rewrite the read index to fetch an entry again.
// - Lost entries are counted; the count saturates at 7F.
// - Lost count returns to zero whenever the read index advances by a pop.
// - Unread count rises per push below capacity and falls per entry read.
// - Entry is three data-port bytes; index advances after the third burst byte.
// - Entry holds tag in bits 23..19 and value in bits 18..0.
// - Each slot pushes channel one with tag slot, then channel two with slot plus six.
// - Almost-full holds when stored entries reach capacity minus the watermark.
// - Enabled almost-full sets its status flag and drives the interrupt pin.
// - Reading interrupt status clears the almost-full flag.
// - On full, overwrite replaces oldest entry; otherwise the new entry is dropped.
// - Type low: flag re-sets on every new sample while almost-full persists.
// - Type high: flag sets only on a fresh almost-full condition.
// - With status-clear option, data port reads also clear almost-full and data-ready.
// - Flush empties buffer, zeroes indexes and counts, then clears itself.
// - Reading an empty buffer returns the invalid tag with zero data.
`ifndef SAMPLE_FIFO_DEFINES_VH
`define SAMPLE_FIFO_DEFINES_VH

`define ADDR_INT_STATUS 8'h00
`define ADDR_INT_ENABLE 8'h03
`define ADDR_WRITE_INDEX 8'h04
`define ADDR_READ_INDEX 8'h05
`define ADDR_LOST_COUNT 8'h06
`define ADDR_UNREAD_COUNT 8'h07
`define ADDR_DATA_PORT 8'h08
`define ADDR_WATERMARK 8'h09
`define ADDR_BUFFER_CONTROL 8'h0A

`define STAT_AFULL_BIT 7
`define STAT_DRDY_BIT 6
`define CTRL_OVERWRITE_BIT 1
`define CTRL_AFULL_TYPE_BIT 2
`define CTRL_STAT_CLEAR_BIT 3
`define CTRL_FLUSH_BIT 4
`define CTRL_TSTAMP_BIT 5

`define FIFO_DEPTH 8'h80
`define LOST_MAX 7'h7F
`define TAG_INVALID 5'h1E
`define TAG_CH2_OFFSET 5'h06
`define BYTES_PER_ENTRY_LAST 2'h2

`define RESET_BYTE 8'h00
`define RESET_INDEX 7'h00

`endif

/* File: hdl/optical_sample_fifo.v */
// 128-entry tagged sample FIFO with index, count and almost-full interrupt logic.
// Assumes the register port and the conversion sequencer run on clk; the serial
// front end raises burst_active for the whole of a multi-byte transaction.
`timescale 1ns/10ps
`include "sample_fifo_defines.vh"

module optical_sample_fifo #(
  parameter DEPTH_LOG2 = 7,
  parameter VALUE_WIDTH = 19,
  parameter TAG_WIDTH = 5
)
(
  input wire clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire burst_active,
  output reg [7:0] reg_rdata,
  input wire conv_valid,
  input wire [2:0] conv_slot,
  input wire [VALUE_WIDTH-1:0] conv_data_one,
  input wire [VALUE_WIDTH-1:0] conv_data_two,
  output reg int_n
);

  localparam ENTRY_WIDTH = TAG_WIDTH + VALUE_WIDTH;
  localparam ENTRIES = 1 << DEPTH_LOG2;

  reg [ENTRY_WIDTH-1:0] entry_mem [0:ENTRIES-1];

  reg [DEPTH_LOG2-1:0] write_index_r;
  reg [DEPTH_LOG2-1:0] read_index_r;
  reg [6:0] lost_entry_count_r;
  reg [7:0] unread_count_r;
  reg [6:0] watermark_r;
  reg overwrite_enable_r;
  reg afull_type_r;
  reg status_clear_option_r;
  reg tstamp_enable_r;
  reg afull_en_r;
  reg drdy_en_r;
  reg afull_flag_r;
  reg drdy_flag_r;
  reg afull_level_d_r;
  reg [1:0] byte_pos_r;
  reg ch2_pending_r;
  reg [ENTRY_WIDTH-1:0] ch2_entry_r;

  reg [DEPTH_LOG2-1:0] write_index_nxt;
  reg [DEPTH_LOG2-1:0] read_index_nxt;
  reg [6:0] lost_entry_count_nxt;
  reg [7:0] unread_count_nxt;
  reg [1:0] byte_pos_nxt;
  reg afull_flag_nxt;
  reg drdy_flag_nxt;
  reg [7:0] rdata_nxt;
  reg int_n_nxt;

  wire wr_ctrl = reg_wr && (reg_addr == `ADDR_BUFFER_CONTROL);
  wire flush = wr_ctrl && reg_wdata[`CTRL_FLUSH_BIT];
  wire wr_read_index = reg_wr && (reg_addr == `ADDR_READ_INDEX);
  wire data_rd = reg_rd && (reg_addr == `ADDR_DATA_PORT);
  wire status_rd = reg_rd && (reg_addr == `ADDR_INT_STATUS);
  wire is_empty = (unread_count_r == 8'h00);

  // Channel one goes straight in; channel two is held one cycle behind it
  wire [ENTRY_WIDTH-1:0] ch1_entry = {{2'b00, conv_slot}, conv_data_one};
  wire [TAG_WIDTH-1:0] ch2_tag = {2'b00, conv_slot} + `TAG_CH2_OFFSET;
  wire push = ch2_pending_r || conv_valid;
  wire [ENTRY_WIDTH-1:0] push_entry = ch2_pending_r ? ch2_entry_r : ch1_entry;

  // Only the third byte of an unbroken burst completes an entry
  wire third_byte = data_rd && burst_active && (byte_pos_r == `BYTES_PER_ENTRY_LAST);
  wire pop = third_byte && !is_empty && !wr_read_index;
  wire full = (unread_count_r == `FIFO_DEPTH) && !pop;
  wire lose = push && full;
  wire store = push && (!full || overwrite_enable_r);

  // Reaching capacity minus watermark, counted with one bit of headroom
  wire [8:0] afull_threshold = {1'b0, `FIFO_DEPTH} - {2'b00, watermark_r};
  wire afull_level = ({1'b0, unread_count_r} >= afull_threshold);
  wire afull_fresh = afull_level && !afull_level_d_r;
  // Type high waits for a fresh crossing; type low re-arms on every push
  reg afull_event;
  always @*
  begin
    if (afull_type_r)
    begin
      afull_event = afull_fresh;
    end
    else
    begin
      afull_event = afull_fresh || (afull_level && push);
    end
  end

  wire [ENTRY_WIDTH-1:0] head_word = is_empty ? {`TAG_INVALID, {VALUE_WIDTH{1'b0}}} :
    entry_mem[read_index_r];

  always @*
  begin
    write_index_nxt = write_index_r;
    read_index_nxt = read_index_r;
    lost_entry_count_nxt = lost_entry_count_r;
    unread_count_nxt = unread_count_r;
    if (store)
    begin
      write_index_nxt = write_index_r + 1'b1;
    end
    if (wr_read_index)
    begin
      read_index_nxt = reg_wdata[DEPTH_LOG2-1:0];
    end
    else if (pop || (store && full))
    begin
      // Overwrite drags the read index past the slot it just clobbered
      read_index_nxt = read_index_r + 1'b1;
    end
    if (pop)
    begin
      lost_entry_count_nxt = 7'h00;
    end
    else if (lose && (lost_entry_count_r != `LOST_MAX))
    begin
      lost_entry_count_nxt = lost_entry_count_r + 1'b1;
    end
    if (store && !full && !pop)
    begin
      unread_count_nxt = unread_count_r + 1'b1;
    end
    else if (pop && !(store && !full))
    begin
      unread_count_nxt = unread_count_r - 1'b1;
    end
    if (flush)
    begin
      write_index_nxt = `RESET_INDEX;
      read_index_nxt = `RESET_INDEX;
      lost_entry_count_nxt = 7'h00;
      unread_count_nxt = 8'h00;
    end
  end

  // Byte position restarts whenever the burst breaks or the index is moved
  always @*
  begin
    byte_pos_nxt = byte_pos_r;
    if (!burst_active || wr_read_index || flush)
    begin
      byte_pos_nxt = 2'h0;
    end
    else if (data_rd)
    begin
      byte_pos_nxt = (byte_pos_r == `BYTES_PER_ENTRY_LAST) ? 2'h0 : byte_pos_r + 1'b1;
    end
  end

  // Hardware set wins over any clear in the same cycle
  always @*
  begin
    afull_flag_nxt = afull_flag_r;
    drdy_flag_nxt = drdy_flag_r;
    if (status_rd || (data_rd && status_clear_option_r))
    begin
      afull_flag_nxt = 1'b0;
      drdy_flag_nxt = 1'b0;
    end
    if (afull_en_r && afull_event)
    begin
      afull_flag_nxt = 1'b1;
    end
    if (drdy_en_r && store)
    begin
      drdy_flag_nxt = 1'b1;
    end
  end

  // Built from the flags' next value so the pin drops on the edge that sets them
  always @*
  begin
    int_n_nxt = !((afull_flag_nxt && afull_en_r) || (drdy_flag_nxt && drdy_en_r));
  end

  always @*
  begin
    case (reg_addr)
      `ADDR_INT_STATUS:
      begin
        rdata_nxt = {afull_flag_r, drdy_flag_r, 6'h00};
      end
      `ADDR_INT_ENABLE:
      begin
        rdata_nxt = {afull_en_r, drdy_en_r, 6'h00};
      end
      `ADDR_WRITE_INDEX:
      begin
        rdata_nxt = {1'b0, write_index_r};
      end
      `ADDR_READ_INDEX:
      begin
        rdata_nxt = {1'b0, read_index_r};
      end
      `ADDR_LOST_COUNT:
      begin
        rdata_nxt = {1'b0, lost_entry_count_r};
      end
      `ADDR_UNREAD_COUNT:
      begin
        rdata_nxt = unread_count_r;
      end
      `ADDR_DATA_PORT:
      begin
        // Most significant byte first, tag leading
        case (byte_pos_r)
          2'h0:
          begin
            rdata_nxt = head_word[23:16];
          end
          2'h1:
          begin
            rdata_nxt = head_word[15:8];
          end
          default:
          begin
            rdata_nxt = head_word[7:0];
          end
        endcase
      end
      `ADDR_WATERMARK:
      begin
        rdata_nxt = {1'b0, watermark_r};
      end
      `ADDR_BUFFER_CONTROL:
      begin
        // Flush never reads back; it acts for one cycle only
        rdata_nxt = {2'b00, tstamp_enable_r, 1'b0, status_clear_option_r, afull_type_r,
          overwrite_enable_r, 1'b0};
      end
      default:
      begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  always @(posedge clk)
  begin
    if (store)
    begin
      entry_mem[write_index_r] <= push_entry;
    end
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      write_index_r <= `RESET_INDEX;
      read_index_r <= `RESET_INDEX;
      lost_entry_count_r <= 7'h00;
      unread_count_r <= 8'h00;
      byte_pos_r <= 2'h0;
      afull_flag_r <= 1'b0;
      drdy_flag_r <= 1'b0;
      afull_level_d_r <= 1'b0;
    end
    else
    begin
      write_index_r <= write_index_nxt;
      read_index_r <= read_index_nxt;
      lost_entry_count_r <= lost_entry_count_nxt;
      unread_count_r <= unread_count_nxt;
      byte_pos_r <= byte_pos_nxt;
      afull_flag_r <= afull_flag_nxt;
      drdy_flag_r <= drdy_flag_nxt;
      afull_level_d_r <= afull_level;
    end
  end

  // Channel two waits here for the cycle after channel one has gone in
  always @(posedge clk)
  begin
    if (reset)
    begin
      ch2_pending_r <= 1'b0;
      ch2_entry_r <= {ENTRY_WIDTH{1'b0}};
    end
    else
    begin
      // A new slot arriving while channel two waits is lost; sequencer spaces them
      ch2_pending_r <= conv_valid && !ch2_pending_r;
      if (conv_valid && !ch2_pending_r)
      begin
        ch2_entry_r <= {ch2_tag, conv_data_two};
      end
    end
  end

  // Both outputs leave straight from flops; read data holds between reads
  always @(posedge clk)
  begin
    if (reset)
    begin
      reg_rdata <= `RESET_BYTE;
      int_n <= 1'b1;
    end
    else
    begin
      if (reg_rd)
      begin
        reg_rdata <= rdata_nxt;
      end
      int_n <= int_n_nxt;
    end
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      watermark_r <= 7'h00;
      overwrite_enable_r <= 1'b0;
      afull_type_r <= 1'b0;
      status_clear_option_r <= 1'b0;
      tstamp_enable_r <= 1'b0;
      afull_en_r <= 1'b0;
      drdy_en_r <= 1'b0;
    end
    else
    begin
      if (reg_wr && (reg_addr == `ADDR_WATERMARK))
      begin
        watermark_r <= reg_wdata[6:0];
      end
      if (wr_ctrl)
      begin
        overwrite_enable_r <= reg_wdata[`CTRL_OVERWRITE_BIT];
        afull_type_r <= reg_wdata[`CTRL_AFULL_TYPE_BIT];
        status_clear_option_r <= reg_wdata[`CTRL_STAT_CLEAR_BIT];
        tstamp_enable_r <= reg_wdata[`CTRL_TSTAMP_BIT];
      end
      if (reg_wr && (reg_addr == `ADDR_INT_ENABLE))
      begin
        afull_en_r <= reg_wdata[`STAT_AFULL_BIT];
        drdy_en_r <= reg_wdata[`STAT_DRDY_BIT];
      end
    end
  end

endmodule // optical_sample_fifo

/* File: verif/sample_fifo_assertions.sv */
// Port checker for the sample FIFO.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module sample_fifo_assertions
(
  input wire clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire conv_valid,
  input wire int_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_index_width: assert property (reg_rd && (reg_addr == 8'h04 || reg_addr == 8'h05) |=> !reg_rdata[7])
    else $error("index above seven bits");
  a_lost_saturates: assert property (reg_rd && reg_addr == 8'h06 |=> reg_rdata <= 8'h7F)
    else $error("lost count above its ceiling");
  a_count_capped: assert property (reg_rd && reg_addr == 8'h07 |=> reg_rdata <= 8'h80)
    else $error("unread count above capacity");
  a_flush_selfclr: assert property (reg_rd && reg_addr == 8'h0A |=> !reg_rdata[4])
    else $error("flush bit reads back set");
  a_int_cause: assert property ($fell(int_n) |-> $past(conv_valid, 1) || $past(conv_valid, 2)
    || $past(conv_valid, 3) || $past(conv_valid, 4) || $past(reg_wr, 1) || $past(reg_wr, 2))
    else $error("interrupt without a push");
  a_status_clears: assert property ((reg_rd && reg_addr == 8'h00 && !conv_valid && !$past(conv_valid)
    && !$past(conv_valid, 2) && !$past(conv_valid, 3)) ##1 !conv_valid |-> ##1 int_n)
    else $error("status read left interrupt low");
  a_int_release: assert property ($rose(int_n) |-> $past(reg_rd, 1) || $past(reg_rd, 2)
    || $past(reg_wr, 1) || $past(reg_wr, 2))
    else $error("interrupt released without access");
  a_index_write: assert property ((reg_wr && reg_addr == 8'h05 && !conv_valid && !$past(conv_valid))
    ##1 !conv_valid ##1 (reg_rd && reg_addr == 8'h05) |=> reg_rdata == ($past(reg_wdata, 3) & 8'h7F))
    else $error("read index not written");
endmodule // sample_fifo_assertions

/* File: verif/host_model.sv */
// Host processor on the register port: single accesses and entry bursts.
// Assumes the block takes requests at the rising edge of clk.
`timescale 1ns/10ps
module host_model
(
  input wire clk,
  output reg [7:0] reg_addr,
  output reg reg_wr,
  output reg reg_rd,
  output reg [7:0] reg_wdata,
  output reg burst_active,
  input wire [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    burst_active = 1'b0;
  end
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  end
  endtask
  task rd(input [7:0] a, output [7:0] d);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  end
  endtask
  // One burst per entry; split reads would restart at byte zero
  task entry(output [23:0] e);
    reg [7:0] b;
    integer i;
  begin
    e = 24'h000000;
    burst_active <= 1'b1;
    for (i = 0; i < 3; i = i + 1)
    begin
      rd(8'h08, b);
      e = {e[15:0], b};
    end
    burst_active <= 1'b0;
    // Let the break be seen before any next burst raises it again
    @(posedge clk);
  end
  endtask
endmodule // host_model

/* File: verif/optical_sample_fifo_tb.sv */
// Self-checking bench for the sample FIFO, host model on the register port.
// Assumes a 50 MHz clock and the register map of the defines header.
`timescale 1ns/10ps
module optical_sample_fifo_tb;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg conv_valid = 1'b0;
  reg [2:0] conv_slot = 3'h0;
  reg [18:0] conv_data_one = 19'h00000;
  reg [18:0] conv_data_two = 19'h00000;
  wire [7:0] reg_addr;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire reg_wr;
  wire reg_rd;
  wire burst_active;
  wire int_n;
  integer num_errors = 0;
  integer samples_checked = 0;
  integer i;
  reg [7:0] b;
  reg [23:0] e;
  always #10 clk = ~clk;
  optical_sample_fifo i_optical_sample_fifo (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .burst_active(burst_active), .reg_rdata(reg_rdata),
    .conv_valid(conv_valid), .conv_slot(conv_slot), .conv_data_one(conv_data_one),
    .conv_data_two(conv_data_two), .int_n(int_n));
  host_model i_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .burst_active(burst_active), .reg_rdata(reg_rdata));
  task cmp(input [95:0] what, input [23:0] exp, input [23:0] got);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("mismatch %0s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  task reg_is(input [7:0] a, input [7:0] exp);
  begin
    i_host_model.rd(a, b);
    cmp("register", {16'h0000, exp}, {16'h0000, b});
  end
  endtask
  task int_is(input exp);
  begin
    repeat (4) @(posedge clk);
    cmp("int_n", {23'h0, exp}, {23'h0, int_n});
  end
  endtask
  // Channel two value differs from channel one so swaps show up
  task push(input [2:0] s);
  begin
    @(posedge clk);
    conv_slot <= s;
    conv_data_one <= {s, 16'hA5C3};
    conv_data_two <= {~s, 16'h3C5A};
    conv_valid <= 1'b1;
    @(posedge clk);
    conv_valid <= 1'b0;
    @(posedge clk);
  end
  endtask
  task get(input [2:0] s, input ch);
  begin
    i_host_model.entry(e);
    cmp("entry", ch ? {{2'b00, s} + 5'h06, ~s, 16'h3C5A} : {2'b00, s, s, 16'hA5C3}, e);
  end
  endtask
  task t_reset;
  begin
    reg_is(8'h04, 8'h00);
    reg_is(8'h05, 8'h00);
    reg_is(8'h06, 8'h00);
    reg_is(8'h07, 8'h00);
    reg_is(8'h0F, 8'h00);
    i_host_model.entry(e);
    cmp("empty tag", 24'h00001E, {19'h0, e[23:19]});
    $display("reset test done");
  end
  endtask
  task t_order;
  begin
    push(3'h1);
    push(3'h2);
    push(3'h3);
    reg_is(8'h04, 8'h06);
    reg_is(8'h07, 8'h06);
    get(3'h1, 1'b0);
    i_host_model.wr(8'h05, 8'h00);
    reg_is(8'h05, 8'h00);
    get(3'h1, 1'b0);
    get(3'h1, 1'b1);
    get(3'h2, 1'b0);
    get(3'h2, 1'b1);
    reg_is(8'h05, 8'h04);
    reg_is(8'h07, 8'h01);
    i_host_model.wr(8'h0A, 8'h10);
    reg_is(8'h04, 8'h00);
    reg_is(8'h05, 8'h00);
    reg_is(8'h07, 8'h00);
    reg_is(8'h0A, 8'h00);
    $display("order test done");
  end
  endtask
  task t_full;
  begin
    i_host_model.wr(8'h09, 8'h10);
    i_host_model.wr(8'h03, 8'h80);
    for (i = 0; i < 55; i = i + 1)
      push(3'h1);
    int_is(1'b1);
    push(3'h1);
    int_is(1'b0);
    reg_is(8'h07, 8'h70);
    for (i = 0; i < 9; i = i + 1)
      push(3'h1);
    reg_is(8'h04, 8'h00);
    reg_is(8'h06, 8'h02);
    reg_is(8'h07, 8'h80);
    get(3'h1, 1'b0);
    reg_is(8'h06, 8'h00);
    reg_is(8'h00, 8'h80);
    int_is(1'b1);
    push(3'h1);
    int_is(1'b0);
    reg_is(8'h06, 8'h01);
    $display("full test done");
  end
  endtask
  task t_overwrite;
  begin
    i_host_model.wr(8'h0A, 8'h06);
    reg_is(8'h00, 8'h80);
    push(3'h2);
    int_is(1'b1);
    reg_is(8'h05, 8'h03);
    reg_is(8'h06, 8'h03);
    reg_is(8'h07, 8'h80);
    get(3'h1, 1'b1);
    i_host_model.wr(8'h0A, 8'h0A);
    push(3'h3);
    int_is(1'b0);
    i_host_model.entry(e);
    int_is(1'b1);
    for (i = 0; i < 70; i = i + 1)
      push(3'h4);
    reg_is(8'h06, 8'h7F);
    $display("overwrite test done");
  end
  endtask
  task close_out;
  begin
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  initial
  begin
    #400000;
    num_errors = num_errors + 1;
    close_out;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_order;
    t_full;
    t_overwrite;
    close_out;
  end
endmodule // optical_sample_fifo_tb
bind optical_sample_fifo sample_fifo_assertions i_sample_fifo_assertions (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .conv_valid(conv_valid), .int_n(int_n));
